// ### verilog/wwd_top.sv
// Purpose: window watchdog with prescaled free-running downcounter and APB registers
// Assumes: option straps are static pins; halt_req comes from the CPU on clk_sys
// Notes: wdg_reset stretches one watchdog event into a fixed-width reset request
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module wwd_top #(
   parameter int PRESCALE_DIV = 4096,
   parameter int RST_PULSE_LEN = wwd_pkg::RST_PULSE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic opt_hw_enable,
   input wire logic opt_reset_on_halt,
   input wire logic halt_req,
   output logic halt_enter,
   output logic wdg_reset
);

   // =====================================================================
   // elaboration checks
   // a prescaler beyond 16 bits or a pulse beyond 8 bits would be cut silently
   if (PRESCALE_DIV < 2 || PRESCALE_DIV > 65536) begin
      $error("PRESCALE_DIV out of range");
   end
   if (RST_PULSE_LEN < 1 || RST_PULSE_LEN > 255) begin
      $error("RST_PULSE_LEN out of range");
   end
   // the window and expiry compares are written for a seven-bit counter
   if (wwd_pkg::CNT_W != 7) begin
      $error("CNT_W must be 7");
   end

   localparam logic [15:0] PRE_LAST = 16'(PRESCALE_DIV - 1);
   localparam logic [7:0] PULSE_LOAD = 8'(RST_PULSE_LEN);

   // =====================================================================
   // option strap synchroniser
   wwd_pkg::wwd_opt_s opt_meta_q, opt_meta_d;
   wwd_pkg::wwd_opt_s opt_q, opt_d;

   // straps arrive from pins, so two flops before any logic reads them
   always_comb begin
      opt_meta_d.hw_enable = opt_hw_enable;
      opt_meta_d.reset_on_halt = opt_reset_on_halt;
      opt_d = opt_meta_q;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         opt_meta_q <= '0;
         opt_q <= '0;
      end else begin
         opt_meta_q <= opt_meta_d;
         opt_q <= opt_d;
      end
   end

   // =====================================================================
   // APB decode
   logic acc_wr, setup_rd, addr_ok;

   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign acc_wr = psel && penable && pwrite;
   assign setup_rd = psel && !penable && !pwrite;
   assign addr_ok = (paddr == wwd_pkg::ADDR_CTRL) || (paddr == wwd_pkg::ADDR_WIN)
                    || (paddr == wwd_pkg::ADDR_STAT);
   assign pslverr = psel && penable && !addr_ok;

   logic wr_ctrl, wr_win;
   // the control byte lives in lane 0, so a write must enable that lane
   assign wr_ctrl = acc_wr && (paddr == wwd_pkg::ADDR_CTRL) && pstrb[0];
   assign wr_win = acc_wr && (paddr == wwd_pkg::ADDR_WIN) && pstrb[0];

   // =====================================================================
   // prescaler
   logic [15:0] pre_q, pre_d;
   logic tick;

   // the prescaler is never cleared by a reload, which is why the timeout
   // is only known to within one prescaler period
   assign tick = (pre_q == PRE_LAST);

   // one tick every PRESCALE_DIV clocks, a single-cycle enable
   always_comb begin
      pre_d = tick ? 16'h0000 : pre_q + 16'h0001;
   end

   // prescaler state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 16'h0000;
      end else begin
         pre_q <= pre_d;
      end
   end

   // =====================================================================
   // downcounter and activate bit
   logic [6:0] cnt_q, cnt_d;
   logic act_q, act_d;

   // a reload beats a tick in the same cycle, so a write at 40h never times out
   always_comb begin
      cnt_d = cnt_q;
      if (wr_ctrl) begin
         cnt_d = pwdata[wwd_pkg::CNT_W-1:0];
      end else if (tick) begin
         cnt_d = cnt_q - 7'h01;                          // free-running, wraps
      end
      // activate only ever sets; only rst_n clears it
      act_d = act_q | (wr_ctrl && pwdata[wwd_pkg::CTRL_ACT_BIT]);
   end

   // counter and activate state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= wwd_pkg::CNT_RESET;
         act_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         act_q <= act_d;
      end
   end

   // =====================================================================
   // window limit register
   logic [6:0] win_q, win_d;

   // only the upper bound is programmable; the lower bound stays at 3Fh
   always_comb begin
      win_d = wr_win ? pwdata[wwd_pkg::CNT_W-1:0] : win_q;
   end

   // window limit state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         win_q <= wwd_pkg::WIN_RESET;
      end else begin
         win_q <= win_d;
      end
   end

   // =====================================================================
   // reset decision
   logic active;
   logic ev_timeout, ev_window, ev_soft, ev_halt, fire;
   logic wr_sets_act;
   logic above_limit, below_floor;

   // hardware option: always on, activate bit has no say
   assign active = opt_q.hw_enable | act_q;
   assign wr_sets_act = pwdata[wwd_pkg::CTRL_ACT_BIT] | opt_q.hw_enable;

   // msb falls 40h -> 3Fh while active
   assign ev_timeout = active && tick && !wr_ctrl && (cnt_q == wwd_pkg::CNT_EXPIRE);
   // upper bound: a reload at or above the limit is too early
   assign above_limit = (cnt_q >= win_q);
   // lower bound: at or below 3Fh the timeout has normally fired already, but
   // the compare still matters when the system reset is not wired back
   assign below_floor = (cnt_q <= wwd_pkg::WIN_FLOOR);
   // reload outside the window
   assign ev_window = active && wr_ctrl && (above_limit || below_floor);
   // writing the msb clear while (becoming) active resets at once
   assign ev_soft = wr_ctrl && (active || wr_sets_act)
                    && !pwdata[wwd_pkg::CNT_MSB_BIT];
   // halt turns into a reset under the reset-on-halt option, only while the watchdog is active
   assign ev_halt = halt_req && active && opt_q.reset_on_halt;
   // any event starts or restarts the reset pulse
   assign fire = ev_timeout || ev_window || ev_soft || ev_halt;

   // =====================================================================
   // reset pulse stretcher
   logic [7:0] pulse_q, pulse_d;
   logic rst_q, rst_d;
   logic halt_q, halt_d;

   // a new event while the pulse runs reloads it, so it is never cut short
   always_comb begin
      pulse_d = pulse_q;
      if (fire) begin
         pulse_d = PULSE_LOAD;
      end else if (pulse_q != 8'h00) begin
         pulse_d = pulse_q - 8'h01;
      end
      rst_d = fire || (pulse_q > 8'h01);
      // halt passes through only when it does not become a reset;
      // refreshing before halt is left to software
      halt_d = halt_req && !ev_halt;
   end

   // pulse, reset and halt outputs are registered
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pulse_q <= 8'h00;
         rst_q <= 1'b0;
         halt_q <= 1'b0;
      end else begin
         pulse_q <= pulse_d;
         rst_q <= rst_d;
         halt_q <= halt_d;
      end
   end

   assign wdg_reset = rst_q;
   assign halt_enter = halt_q;

   // =====================================================================
   // reset cause record
   wwd_pkg::wwd_cause_e cause_q, cause_d;

   // the cause survives until a later event or the system reset through rst_n replaces it,
   // so software can still read it if the reset is not wired back;
   // when events coincide the most specific one is kept
   always_comb begin
      cause_d = cause_q;
      if (fire) begin
         if (ev_soft) begin
            cause_d = wwd_pkg::CAUSE_SOFT;
         end else if (ev_window) begin
            cause_d = wwd_pkg::CAUSE_WINDOW;
         end else if (ev_halt) begin
            cause_d = wwd_pkg::CAUSE_HALT;
         end else begin
            cause_d = wwd_pkg::CAUSE_TIMEOUT;
         end
      end
   end

   // cause state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cause_q <= wwd_pkg::CAUSE_NONE;
      end else begin
         cause_q <= cause_d;
      end
   end

   // =====================================================================
   // read data, captured in the setup cycle
   logic [31:0] rd_q, rd_d;

   always_comb begin
      rd_d = rd_q;
      if (setup_rd) begin
         rd_d = 32'h0000_0000;
         case (paddr)
            wwd_pkg::ADDR_CTRL: begin
               rd_d[wwd_pkg::CTRL_ACT_BIT] = act_q;
               rd_d[wwd_pkg::CNT_W-1:0] = cnt_q;
            end
            wwd_pkg::ADDR_WIN: begin
               rd_d[wwd_pkg::CNT_W-1:0] = win_q;
            end
            wwd_pkg::ADDR_STAT: begin
               rd_d[wwd_pkg::STAT_ACTIVE_BIT] = active;
               rd_d[wwd_pkg::STAT_HW_OPT_BIT] = opt_q.hw_enable;
               rd_d[wwd_pkg::STAT_HALT_OPT_BIT] = opt_q.reset_on_halt;
               rd_d[wwd_pkg::STAT_RST_BIT] = rst_q;
               rd_d[6:4] = cause_q;
            end
            default: begin
               rd_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 32'h0000_0000;
      end else begin
         rd_q <= rd_d;
      end
   end

   assign prdata = rd_q;

endmodule

`default_nettype wire

// ### include/wwd_pkg.sv
// Purpose: shared constants and types of the window watchdog block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: byte addresses; narrow registers sit in the low bits
package wwd_pkg;

   // =====================================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;   // watchdog_control_reg
   localparam logic [7:0] ADDR_WIN = 8'h04;    // window_limit_reg
   localparam logic [7:0] ADDR_STAT = 8'h08;   // live status

   // =====================================================================
   // control register layout
   localparam int CTRL_ACT_BIT = 7;            // watchdog_activate
   localparam int CNT_MSB_BIT = 6;             // counter_msb_bit
   localparam int CNT_W = 7;

   // =====================================================================
   // status register layout
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_HW_OPT_BIT = 1;
   localparam int STAT_HALT_OPT_BIT = 2;
   localparam int STAT_RST_BIT = 3;

   // =====================================================================
   // reset values and fixed counter points
   localparam logic [6:0] CNT_RESET = 7'h7F;
   localparam logic [6:0] WIN_RESET = 7'h7F;
   localparam logic [6:0] CNT_EXPIRE = 7'h40;  // last value with msb set
   localparam logic [6:0] WIN_FLOOR = 7'h3F;   // lower bound of reload window

   // =====================================================================
   // timing
   localparam int CLK_MHZ = 250;
   localparam int RST_PULSE_NS = 1000;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;

   // reset reasons, held for the status read
   typedef enum logic [2:0] {
      CAUSE_NONE = 3'b000,
      CAUSE_TIMEOUT = 3'b001,
      CAUSE_WINDOW = 3'b010,
      CAUSE_SOFT = 3'b011,
      CAUSE_HALT = 3'b100
   } wwd_cause_e;

   // option-byte straps, carried together
   typedef struct packed {
      logic hw_enable;
      logic reset_on_halt;
   } wwd_opt_s;

endpackage

// ### verification/wwd_top_sva.sv
// Purpose: port assertions for wwd_top
// Assumes: bound from the bench top file
// Notes: the counter is internal, so only port relations are checked
`timescale 1ns/1ns
`default_nettype none
// ==========
// checker
module wwd_top_sva #(
   parameter int RST_PULSE_LEN = wwd_pkg::RST_PULSE_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic halt_req,
   input wire logic halt_enter,
   input wire logic wdg_reset
);
   logic [15:0] hi_q;
   logic [15:0] hi_d;
   logic acc;
   logic mapped;
   // access phase and decoded address
   assign acc = psel && penable;
   assign mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
   // length of the current reset pulse
   always_comb hi_d = wdg_reset ? hi_q + 16'h1 : 16'h0;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) hi_q <= 16'h0;
      else hi_q <= hi_d;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   rdy_high_a: assert property (pready) else $error("pready low");
   err_bad_a: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
   err_good_a: assert property (pslverr |-> acc && !mapped) else $error("stray pslverr");
   rd_bad_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   rd_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   soft_rst_a: assert property (acc && pwrite && pstrb[0] && paddr == 8'h00
      && pwdata[7:6] == 2'b10 |-> ##[1:2] wdg_reset) else $error("no soft reset");
   pulse_len_a: assert property ($fell(wdg_reset) |-> hi_q >= RST_PULSE_LEN)
      else $error("reset pulse short");
   halt_src_a: assert property (halt_enter |-> $past(halt_req))
      else $error("halt without request");
   halt_out_a: assert property (halt_req |-> ##[1:2] (halt_enter || wdg_reset))
      else $error("halt request lost");
endmodule
`default_nettype wire

// ### verification/tb_window_watchdog.sv
// Purpose: self-checking bench for the window watchdog
// Assumes: short prescaler and reset pulse
// Notes: pulses of wdg_reset and halt_enter are counted
`timescale 1ns/1ns
`default_nettype none
// ==========
// bench
module tb_window_watchdog;
   localparam int DIV = 8;
   localparam int PLEN = 4;
   logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic opt_hw = 1'b0, opt_halt = 1'b0, halt_req = 1'b0, er, wr_q;
   logic pready, pslverr, halt_enter, wdg_reset;
   logic [7:0] paddr = 8'h00;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int miscompares, checks_done, rises, halts, cyc, t;
   wwd_top #(.PRESCALE_DIV(DIV), .RST_PULSE_LEN(PLEN)) i_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .opt_hw_enable(opt_hw), .opt_reset_on_halt(opt_halt),
      .halt_req(halt_req), .halt_enter(halt_enter), .wdg_reset(wdg_reset));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   // pulse counters; the cycle ceiling stops a hang
   always @(posedge clk_sys) begin
      wr_q <= wdg_reset;
      if (wdg_reset === 1'b1 && wr_q !== 1'b1) rises++;
      if (halt_enter === 1'b1) halts++;
      cyc++;
      if (cyc == 10000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, then an idle edge so no signal moves twice at one edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // wait states end only on pready; the cycle ceiling guards a hang
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic restart(input logic hw, input logic hl);
      rst_n <= 1'b0;
      opt_hw <= hw;
      opt_halt <= hl;
      repeat (6) @(posedge clk_sys);
      rises = 0;
      halts = 0;
      rst_n <= 1'b1;
      repeat (23) @(posedge clk_sys);
   endtask
   task automatic stat(input logic act, input logic [2:0] cause, input int k);
      repeat (2) @(posedge clk_sys);
      bus(1'b0, 8'h08, 32'h0);
      check("active", {31'h0, act}, {31'h0, rd[0]});
      check("cause", {29'h0, cause}, {29'h0, rd[6:4]});
      check("resets", k, rises);
   endtask
   task automatic halt_pulse();
      halt_req <= 1'b1;
      @(posedge clk_sys);
      halt_req <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   // ==========
   // scenarios
   initial begin
      restart(1'b0, 1'b0);
      bus(1'b0, 8'h04, 32'h0);
      check("window", 32'h7F, rd);
      bus(1'b1, 8'h0C, 32'hFF);
      check("slverr", 32'h1, {31'h0, er});
      bus(1'b0, 8'h0C, 32'h0);
      check("unmapped", 32'h0, rd);
      // counter runs past 40h while off, and no reset follows
      repeat (600) @(posedge clk_sys);
      bus(1'b0, 8'h00, 32'h0);
      check("counting", 32'h1, {31'h0, rd[6:0] < 7'h70});
      stat(1'b0, wwd_pkg::CAUSE_NONE, 0);
      restart(1'b0, 1'b0);
      bus(1'b1, 8'h04, 32'h50);
      // first write only enables; the second is a reload above the limit
      bus(1'b1, 8'h00, 32'hFF);
      bus(1'b1, 8'h00, 32'hFF);
      stat(1'b1, wwd_pkg::CAUSE_WINDOW, 1);
      restart(1'b0, 1'b0);
      bus(1'b1, 8'h00, 32'hFF);
      repeat (20) @(posedge clk_sys);
      bus(1'b1, 8'h00, 32'hFF);
      stat(1'b1, wwd_pkg::CAUSE_NONE, 0);
      for (t = 0; t < 700 && rises == 0; t++) @(posedge clk_sys);
      check("timeout", 32'h1, {31'h0, t > 62 * DIV && t < 64 * DIV});
      stat(1'b1, wwd_pkg::CAUSE_TIMEOUT, 1);
      restart(1'b0, 1'b0);
      bus(1'b1, 8'h00, 32'hBF);
      stat(1'b1, wwd_pkg::CAUSE_SOFT, 1);
      // counter now at or below 3Fh: a reload there is below the window
      bus(1'b1, 8'h00, 32'hFF);
      stat(1'b1, wwd_pkg::CAUSE_WINDOW, 2);
      restart(1'b0, 1'b1);
      halt_pulse();
      check("halt", 32'h1, halts);
      bus(1'b1, 8'h00, 32'hFF);
      halt_pulse();
      stat(1'b1, wwd_pkg::CAUSE_HALT, 1);
      check("halt", 32'h1, halts);
      restart(1'b1, 1'b0);
      // refresh inside the window, then halt without reset
      bus(1'b1, 8'h00, 32'hFF);
      halt_pulse();
      check("halt", 32'h1, halts);
      repeat (16) @(posedge clk_sys);
      bus(1'b1, 8'h00, 32'h3F);
      stat(1'b1, wwd_pkg::CAUSE_SOFT, 1);
      conclude();
   end
endmodule
bind wwd_top wwd_top_sva #(.RST_PULSE_LEN(RST_PULSE_LEN)) u_sva (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .halt_req(halt_req), .halt_enter(halt_enter), .wdg_reset(wdg_reset));
`default_nettype wire
